// File: cifl_top.sv
// Purpose: Interrupt enable, stack select, priority level and register banks
// Assumes: Requests and commands come from core logic on mclk
// Notes: Acceptance is a one-cycle pulse; flags update on the same edge as the pulse
//
// Overview of operation
// - Maskable requests are blocked while the enable flag is zero.
// - Accepting any interrupt clears the enable flag.
// - Stack select zero picks interrupt stack pointer, one picks user stack pointer.
// - Accepting a hardware interrupt clears the stack select flag.
// - Software interrupt numbers 0 to 31 clear stack select; higher leave it.
// - Two banks of seven registers: four data, two address, frame base.
// - Three-bit processor level; a maskable request must exceed it to be enabled.
`timescale 1ns/1ps
`default_nettype none
module cifl_top #(
  parameter int unsigned width = cifl_pkg::data_width
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Interrupt and instruction events
  input wire cifl_pkg::cifl_irq_type irq,
  input wire cifl_pkg::cifl_flag_cmd_type cmd,
  // Stack pointer writes
  input wire logic isp_we,
  input wire logic usp_we,
  input wire logic [cifl_pkg::addr_width-1:0] sp_wdata,
  // Register bank access
  input wire cifl_pkg::cifl_reg_wr_type reg_wr,
  input wire logic [cifl_pkg::reg_sel_width-1:0] reg_rd_sel,
  // Status out
  output logic irq_accept,
  output logic swi_accept,
  output cifl_pkg::cifl_flags_type flags,
  output logic [cifl_pkg::addr_width-1:0] active_sp,
  output logic [width-1:0] reg_rd_data
);
  typedef struct packed {
    cifl_pkg::cifl_flags_type flags;
    logic [cifl_pkg::addr_width-1:0] interrupt_stack_pointer;
    logic [cifl_pkg::addr_width-1:0] user_stack_pointer;
    logic [cifl_pkg::addr_width-1:0] active_sp;
    logic irq_accept;
    logic swi_accept;
    logic [width-1:0] rd_data;
  } cifl_state_type;

  cifl_state_type state_r;
  cifl_state_type state_nxt;
  logic hw_take;
  logic [width-1:0] bank_rd;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic prio_enabled(input logic [cifl_pkg::ipl_width-1:0] p,
                                        input logic [cifl_pkg::ipl_width-1:0] lvl);
    prio_enabled = (p > lvl);
  endfunction

  assign hw_take = irq.hw_req &&
                   (irq.nonmaskable ||
                    (state_r.flags.ien && prio_enabled(irq.hw_prio, state_r.flags.processor_priority_level)));

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    state_nxt.irq_accept = hw_take;
    state_nxt.swi_accept = irq.swi_exec;
    if (cmd.set_ien) begin
      state_nxt.flags.ien = 1'b1;
    end
    if (cmd.clr_ien) begin
      state_nxt.flags.ien = 1'b0;
    end
    if (cmd.set_stk) begin
      state_nxt.flags.stk = 1'b1;
    end
    if (cmd.clr_stk) begin
      state_nxt.flags.stk = 1'b0;
    end
    if (cmd.ipl_we) begin
      state_nxt.flags.processor_priority_level = cmd.ipl_val;
    end
    if (cmd.bank_we) begin
      state_nxt.flags.bank = cmd.bank_val;
    end
    // clear enable on acceptance, hardware over software writes
    if (hw_take || irq.swi_exec) begin
      state_nxt.flags.ien = 1'b0;
    end
    if (hw_take) begin
      state_nxt.flags.stk = 1'b0;
    end
    if (irq.swi_exec && (irq.swi_num <= cifl_pkg::swi_last_low)) begin
      state_nxt.flags.stk = 1'b0;
    end
    if (isp_we) begin
      state_nxt.interrupt_stack_pointer = sp_wdata;
    end
    if (usp_we) begin
      state_nxt.user_stack_pointer = sp_wdata;
    end
    // stack pointer choice follows the next flag value
    state_nxt.active_sp = state_nxt.flags.stk ? state_nxt.user_stack_pointer
                                              : state_nxt.interrupt_stack_pointer;
    state_nxt.rd_data = bank_rd;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
      state_r.flags.ien <= cifl_pkg::flag_ien_reset;
      state_r.flags.stk <= cifl_pkg::flag_stk_reset;
      state_r.flags.bank <= cifl_pkg::flag_bank_reset;
      state_r.flags.processor_priority_level <= cifl_pkg::ipl_reset;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // banked register file
  cifl_bank_file #(
    .width(width),
    .banks(cifl_pkg::bank_count),
    .regs(cifl_pkg::bank_regs)
  ) u_bank (
    .mclk(mclk),
    .arst_n(arst_n),
    .bank(state_r.flags.bank),
    .wr(reg_wr),
    .rd_sel(reg_rd_sel),
    .rd_data(bank_rd)
  );

  assign irq_accept = state_r.irq_accept;
  assign swi_accept = state_r.swi_accept;
  assign flags = state_r.flags;
  assign active_sp = state_r.active_sp;
  assign reg_rd_data = state_r.rd_data;

  ////////////////////////////////////////////////////////////////////////////////
  // mask, priority, flag, stack pointer and bank checks
  chk_mask_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.hw_req && !irq.nonmaskable && !state_r.flags.ien) |=> !irq_accept)
    else $error("masked request accepted");
  chk_accept_clears_ien: assert property (@(posedge mclk) disable iff (!arst_n)
    (hw_take || irq.swi_exec) |=> !flags.ien)
    else $error("enable flag not cleared");
  chk_sp_select: assert property (@(posedge mclk) disable iff (!arst_n)
    active_sp == (flags.stk ? state_r.user_stack_pointer : state_r.interrupt_stack_pointer))
    else $error("wrong active stack pointer");
  chk_hw_clears_stk: assert property (@(posedge mclk) disable iff (!arst_n)
    hw_take |=> (!flags.stk && irq_accept))
    else $error("stack select not cleared");
  chk_swi_high_keeps: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.swi_exec && irq.swi_num > cifl_pkg::swi_last_low && !hw_take &&
     !cmd.set_stk && !cmd.clr_stk) |=> flags.stk == $past(state_r.flags.stk))
    else $error("high software number changed stack select");
  chk_swi_low_clears: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.swi_exec && irq.swi_num <= cifl_pkg::swi_last_low) |=> !flags.stk)
    else $error("low software number kept stack select");
  chk_bank_read: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_wr.we && int'(reg_wr.sel) < cifl_pkg::bank_regs && !cmd.bank_we)
    ##1 (reg_rd_sel == $past(reg_wr.sel) && !reg_wr.we && !cmd.bank_we)
    |=> reg_rd_data == $past(reg_wr.wdata, 2))
    else $error("bank write not read back");
  chk_prio_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.hw_req && !irq.nonmaskable && irq.hw_prio <= state_r.flags.processor_priority_level) |=> !irq_accept)
    else $error("low priority accepted");
  chk_accept_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.hw_req && !irq.nonmaskable && state_r.flags.ien &&
     irq.hw_prio > state_r.flags.processor_priority_level) |=> irq_accept)
    else $error("eligible request not accepted");
  chk_nmi_bypass: assert property (@(posedge mclk) disable iff (!arst_n)
    (irq.hw_req && irq.nonmaskable) |=> (irq_accept && !flags.ien && !flags.stk))
    else $error("nonmaskable request not taken");
  chk_idle_no_accept: assert property (@(posedge mclk) disable iff (!arst_n)
    !irq.hw_req |=> !irq_accept)
    else $error("accept without request");
  chk_swi_echo: assert property (@(posedge mclk) disable iff (!arst_n)
    irq.swi_exec |=> swi_accept)
    else $error("software interrupt not echoed");
  chk_swi_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    !irq.swi_exec |=> !swi_accept)
    else $error("stray software accept");
  chk_ien_set: assert property (@(posedge mclk) disable iff (!arst_n)
    (cmd.set_ien && !cmd.clr_ien && !hw_take && !irq.swi_exec) |=> flags.ien)
    else $error("enable flag not set");
  chk_ien_holds: assert property (@(posedge mclk) disable iff (!arst_n)
    (!cmd.set_ien && !cmd.clr_ien && !hw_take && !irq.swi_exec) |=> $stable(flags.ien))
    else $error("enable flag changed without cause");
  chk_stk_set: assert property (@(posedge mclk) disable iff (!arst_n)
    (cmd.set_stk && !cmd.clr_stk && !hw_take && !irq.swi_exec) |=> flags.stk)
    else $error("stack select not set");
  chk_ipl_write: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd.ipl_we |=> flags.processor_priority_level == $past(cmd.ipl_val))
    else $error("level not written");
  chk_ipl_holds: assert property (@(posedge mclk) disable iff (!arst_n)
    !cmd.ipl_we |=> $stable(flags.processor_priority_level))
    else $error("level changed without write");
  chk_bank_select: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd.bank_we |=> flags.bank == $past(cmd.bank_val))
    else $error("bank not selected");
endmodule
`default_nettype wire

// File: cifl_pkg.sv
// Purpose: Shared types and constants for the interrupt flag logic
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Flag reset values chosen so interrupts start masked on the interrupt stack
package cifl_pkg;
  localparam int unsigned data_width = 16;
  localparam int unsigned addr_width = 16;
  localparam int unsigned bank_count = 2;
  localparam int unsigned bank_regs = 7;
  localparam int unsigned reg_sel_width = 3;
  localparam int unsigned ipl_width = 3;
  localparam int unsigned swi_num_width = 6;
  localparam logic [swi_num_width-1:0] swi_last_low = 6'h1f;
  localparam logic flag_ien_reset = 1'h0;
  localparam logic flag_stk_reset = 1'h0;
  localparam logic flag_bank_reset = 1'h0;
  localparam logic [ipl_width-1:0] ipl_reset = 3'h0;
  localparam logic [data_width-1:0] reg_reset = 16'h0000;

  // Bank member indices
  localparam logic [reg_sel_width-1:0] sel_data_reg_zero = 3'h0;
  localparam logic [reg_sel_width-1:0] sel_data_reg_one = 3'h1;
  localparam logic [reg_sel_width-1:0] sel_data_reg_two = 3'h2;
  localparam logic [reg_sel_width-1:0] sel_data_reg_three = 3'h3;
  localparam logic [reg_sel_width-1:0] sel_address_reg_zero = 3'h4;
  localparam logic [reg_sel_width-1:0] sel_address_reg_one = 3'h5;
  localparam logic [reg_sel_width-1:0] sel_frame_base_register = 3'h6;

  typedef struct packed {
    logic hw_req;
    logic [ipl_width-1:0] hw_prio;
    logic nonmaskable;
    logic swi_exec;
    logic [swi_num_width-1:0] swi_num;
  } cifl_irq_type;

  typedef struct packed {
    logic set_ien;
    logic clr_ien;
    logic set_stk;
    logic clr_stk;
    logic ipl_we;
    logic [ipl_width-1:0] ipl_val;
    logic bank_we;
    logic bank_val;
  } cifl_flag_cmd_type;

  typedef struct packed {
    logic we;
    logic [reg_sel_width-1:0] sel;
    logic [data_width-1:0] wdata;
  } cifl_reg_wr_type;

  typedef struct packed {
    logic ien;
    logic stk;
    logic bank;
    logic [ipl_width-1:0] processor_priority_level;
  } cifl_flags_type;
endpackage

// File: cifl_bank_file.sv
// Purpose: Two banks of seven core registers with one write and one read port
// Assumes: Write and read select the same active bank
// Notes: Read is combinational; the top registers it
`timescale 1ns/1ps
`default_nettype none
module cifl_bank_file #(
  parameter int unsigned width = cifl_pkg::data_width,
  parameter int unsigned banks = cifl_pkg::bank_count,
  parameter int unsigned regs = cifl_pkg::bank_regs
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Access
  input wire logic bank,
  input wire cifl_pkg::cifl_reg_wr_type wr,
  input wire logic [cifl_pkg::reg_sel_width-1:0] rd_sel,
  output logic [width-1:0] rd_data
);
  typedef struct packed {
    logic [banks-1:0][regs-1:0][width-1:0] mem;
  } cifl_bank_state_type;

  cifl_bank_state_type state_r;
  cifl_bank_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (wr.we && (int'(wr.sel) < regs)) begin
      state_nxt.mem[bank][wr.sel] = wr.wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    rd_data = '0;
    if (int'(rd_sel) < regs) begin
      rd_data = state_r.mem[bank][rd_sel];
    end
  end
endmodule
`default_nettype wire

// File: cifl_testbench.sv
// Purpose: Self-checking bench for the interrupt flag logic top
// Assumes: Inputs change 1 ns after the rising edge; outputs read there
// Notes: Each scenario is its own task; checks use one compare macro
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  cifl_pkg::cifl_irq_type irq = '0;
  cifl_pkg::cifl_flag_cmd_type cmd = '0;
  logic isp_we = 1'h0;
  logic usp_we = 1'h0;
  logic [15:0] sp_wdata = 16'h0000;
  cifl_pkg::cifl_reg_wr_type reg_wr = '0;
  logic [2:0] reg_rd_sel = 3'h0;
  logic irq_accept;
  logic swi_accept;
  cifl_pkg::cifl_flags_type flags;
  logic [15:0] active_sp;
  logic [15:0] reg_rd_data;
  int mismatches = 0;
  int n_compared = 0;

  `define check_eq(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin \
    mismatches++; $display("mismatch at %0t: %s", $time, msg); end end

  cifl_top uut (.mclk(mclk), .arst_n(arst_n), .irq(irq), .cmd(cmd), .isp_we(isp_we),
    .usp_we(usp_we), .sp_wdata(sp_wdata), .reg_wr(reg_wr), .reg_rd_sel(reg_rd_sel),
    .irq_accept(irq_accept), .swi_accept(swi_accept), .flags(flags),
    .active_sp(active_sp), .reg_rd_data(reg_rd_data));

  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Drive just after the edge so the design samples stable values
  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_state();
    `check_eq(flags, 6'h00, "flags after reset")
    `check_eq(active_sp, 16'h0000, "sp after reset")
    `check_eq(irq_accept, 1'h0, "accept after reset")
    `check_eq(swi_accept, 1'h0, "software accept after reset")
    `check_eq(reg_rd_data, 16'h0000, "read data after reset")
  endtask

  task automatic stack_select();
    isp_we = 1'h1;
    sp_wdata = 16'h1234;
    step();
    isp_we = 1'h0;
    usp_we = 1'h1;
    sp_wdata = 16'h5678;
    step();
    usp_we = 1'h0;
    `check_eq(active_sp, 16'h1234, "interrupt stack not active")
    cmd.set_stk = 1'h1;
    step();
    cmd = '0;
    `check_eq(flags.stk, 1'h1, "stack flag not set")
    `check_eq(active_sp, 16'h5678, "user stack not active")
  endtask

  task automatic masked_request();
    irq.hw_req = 1'h1;
    irq.hw_prio = 3'h7;
    step();
    `check_eq(irq_accept, 1'h0, "accepted while disabled")
    step();
    irq.hw_req = 1'h0;
    `check_eq(irq_accept, 1'h0, "accepted while disabled")
    `check_eq(flags.stk, 1'h1, "stack flag lost on refusal")
  endtask

  // Enable is off and the level is above the request, so only the bypass can take it
  task automatic nonmask_request();
    cmd.set_stk = 1'h1;
    step();
    cmd = '0;
    irq.hw_req = 1'h1;
    irq.nonmaskable = 1'h1;
    irq.hw_prio = 3'h0;
    step();
    irq = '0;
    `check_eq(irq_accept, 1'h1, "nonmaskable request refused")
    `check_eq(flags.ien, 1'h0, "enable set after nonmaskable")
    `check_eq(flags.stk, 1'h0, "stack flag kept on nonmaskable")
    `check_eq(active_sp, 16'h1234, "sp not switched on nonmaskable")
    step();
    `check_eq(irq_accept, 1'h0, "nonmaskable pulse too long")
  endtask

  task automatic level_gate();
    cmd.ipl_we = 1'h1;
    cmd.ipl_val = 3'h2;
    cmd.set_ien = 1'h1;
    step();
    cmd = '0;
    `check_eq(flags.ien, 1'h1, "enable not set")
    `check_eq(flags.processor_priority_level, 3'h2, "level not written")
    irq.hw_req = 1'h1;
    irq.hw_prio = 3'h2;
    step();
    `check_eq(irq_accept, 1'h0, "equal priority accepted")
    irq.hw_prio = 3'h3;
    step();
    irq.hw_req = 1'h0;
    `check_eq(irq_accept, 1'h1, "higher priority refused")
    `check_eq(flags.ien, 1'h0, "enable kept on accept")
    `check_eq(flags.stk, 1'h0, "stack flag kept on accept")
    `check_eq(active_sp, 16'h1234, "sp not switched on accept")
    step();
    `check_eq(irq_accept, 1'h0, "accept pulse too long")
  endtask

  task automatic soft_interrupts();
    logic [5:0] nums [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
    for (int i = 0; i < 4; i++) begin
      cmd.set_stk = 1'h1;
      cmd.set_ien = 1'h1;
      step();
      cmd = '0;
      irq.swi_exec = 1'h1;
      irq.swi_num = nums[i];
      step();
      irq.swi_exec = 1'h0;
      `check_eq(swi_accept, 1'h1, "software interrupt missed")
      `check_eq(flags.ien, 1'h0, "enable kept on software interrupt")
      `check_eq(flags.stk, (nums[i] > 6'h1f), "stack flag by number")
    end
  endtask

  task automatic banks();
    for (int b = 0; b < 2; b++) begin
      cmd.bank_we = 1'h1;
      cmd.bank_val = 1'(b);
      step();
      cmd = '0;
      `check_eq(flags.bank, 1'(b), "bank not selected")
      for (int s = 0; s < 7; s++) begin
        reg_wr.we = 1'h1;
        reg_wr.sel = 3'(s);
        reg_wr.wdata = 16'ha000 + 16'(b * 16 + s);
        step();
      end
      reg_wr = '0;
    end
    for (int b = 0; b < 2; b++) begin
      cmd.bank_we = 1'h1;
      cmd.bank_val = 1'(b);
      step();
      cmd = '0;
      for (int s = 0; s < 8; s++) begin
        reg_rd_sel = 3'(s);
        step();
        `check_eq(reg_rd_data, (s == 7) ? 16'h0000 : 16'ha000 + 16'(b * 16 + s), "bank")
      end
    end
    // Write then read next cycle in bank one; bank zero must keep its own copy
    reg_wr.we = 1'h1;
    reg_wr.sel = 3'h2;
    reg_wr.wdata = 16'h5a5a;
    step();
    reg_wr = '0;
    reg_rd_sel = 3'h2;
    step();
    `check_eq(reg_rd_data, 16'h5a5a, "write not read back")
    cmd.bank_we = 1'h1;
    cmd.bank_val = 1'h0;
    step();
    cmd = '0;
    step();
    `check_eq(reg_rd_data, 16'ha002, "other bank overwritten")
    step();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'h1;
    reset_state();
    stack_select();
    masked_request();
    level_gate();
    nonmask_request();
    soft_interrupts();
    banks();
    results();
  end
endmodule
`default_nettype wire
